// [design/flash_program_erase_controller.sv]
// Flash program/erase sequencer with unlock, control register and latches
// Behaviour
// R1: Software writes 55h then AAh to key.
// R2: No start without unlock directly before.
// R3: Destination from high byte plus low word.
// R4: Chip erase ignores destination address.
// R5: Core stalled until operation finishes.
// R6: Start bit launches, hardware clears it.
// R7: Enable bit zero inhibits program and erase.
// R8: Fault flag set on bad attempt, termination.
// R9: Idle select: power off or standby.
// R10: Bits 11-4 read zero, reserved written zero.
// R11: Code 1110 chip erase, 0100 unused.
// R12: Codes page erase, row, double word.
// R13: Unimplemented codes perform no operation.
// R14: Control bits reset only at power-on.
// R15: Page erase clears 1024-instruction aligned block.
// R16: Row program writes 128 latch words.
// R17: Software erase set-up order.
// R18: Software inserts two nops, then waits.
// R19: Software writes 0x4003 or 0x4002.
// R20: Software loads latches through page 0xfa.
// R21: Software blocks interrupts around unlock.
// R22: Table writes land in holding latches.
// R23: Latches power up unknown.
// R24: Key tracker arms only on adjacent pair.
// R25: Bad start sets fault, starts nothing.
module flash_program_erase_controller #(
  parameter int unsigned PAGE_ERASE_CYCLES = flash_pkg::PAGE_ERASE_CYCLES,
  parameter int unsigned CHIP_ERASE_CYCLES = flash_pkg::CHIP_ERASE_CYCLES,
  parameter int unsigned WORD_PROG_CYCLES  = flash_pkg::WORD_PROG_CYCLES
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  sys_rst_b,
  input  wire logic                  idle_req,
  input  wire flash_pkg::reg_wr_s    reg_wr,
  input  wire flash_pkg::latch_wr_s  latch_wr,
  output logic [15:0]                ctrl_rdata,
  output logic [23:0]                dest_rdata,
  output logic                       cpu_stall,
  output logic                       mem_power_off,
  output logic                       mem_standby,
  output flash_pkg::flash_cmd_s      flash_cmd
);
  import flash_pkg::*;

  typedef enum logic [2:0] {
    KEY_IDLE  = 3'b001,
    KEY_HALF  = 3'b010,
    KEY_ARMED = 3'b100
  } key_e;

  typedef enum logic [4:0] {
    SEQ_IDLE   = 5'b00001,
    SEQ_ERASE  = 5'b00010,
    SEQ_PROG   = 5'b00100,
    SEQ_WAIT   = 5'b01000,
    SEQ_FINISH = 5'b10000
  } seq_e;

  logic        rst_meta_r;
  logic        rst_sync_r;
  logic        start_r;
  logic        allow_r;
  logic        fault_r;
  logic        idle_off_r;
  logic [3:0]  op_r;
  logic [7:0]  dest_high_r;
  logic [15:0] dest_low_r;
  key_e        key_r;
  seq_e        seq_r;
  logic [15:0] timer_r;
  logic [6:0]  idx_r;
  logic [6:0]  last_idx_r;
  logic [23:0] cur_addr_r;
  logic [23:0] latch_mem [ROW_WORDS];
  logic        ctrl_wr;
  logic        key_wr;
  logic        start_try;
  logic        start_go;
  logic        start_fault;
  logic        seq_abort;
  logic [3:0]  wr_op;
  logic [23:0] dest_addr;
  // ==========================================================================
  // Reset release
  // Power-on reset is released through two flops to avoid a ragged release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ==========================================================================
  // Decode
  function automatic logic op_valid(input logic [3:0] op);
    // R13: unknown codes refused
    op_valid = (op == OP_CHIP_ERASE) || (op == OP_PAGE_ERASE) ||
               (op == OP_ROW_PROG) || (op == OP_DWORD_PROG);
  endfunction

  // Control writes are dropped while busy; the core is stalled anyway
  assign ctrl_wr   = reg_wr.en && (reg_wr.sel == SEL_CTRL) && (seq_r == SEQ_IDLE);
  assign key_wr    = reg_wr.en && (reg_wr.sel == SEL_KEY);
  assign wr_op     = reg_wr.data[CTRL_OP_MSB:CTRL_OP_LSB];
  assign start_try = ctrl_wr && reg_wr.data[CTRL_START_BIT];
  // R2: start needs armed key
  // R7: enable bit gates start
  assign start_go  = start_try && (key_r == KEY_ARMED) &&
                     reg_wr.data[CTRL_ALLOW_BIT] && op_valid(wr_op);
  // R25: refused start flags fault
  assign start_fault = start_try && !start_go;
  // R8: other reset mid-operation terminates
  assign seq_abort = !sys_rst_b && (seq_r != SEQ_IDLE);
  // R3: high byte over low word
  assign dest_addr = {dest_high_r, dest_low_r};

  // ==========================================================================
  // Unlock tracker
  // R24: adjacent key pair arms
  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      key_r <= KEY_IDLE;
    end else if (!sys_rst_b) begin
      key_r <= KEY_IDLE;
    end else if (reg_wr.en) begin
      case (key_r)
        KEY_IDLE:  key_r <= (key_wr && reg_wr.data == KEY_FIRST) ? KEY_HALF : KEY_IDLE;
        KEY_HALF:  key_r <= (key_wr && reg_wr.data == KEY_SECOND) ? KEY_ARMED : KEY_IDLE;
        // Armed state is spent by whatever register write comes next
        KEY_ARMED: key_r <= KEY_IDLE;
        default:   key_r <= KEY_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Control register
  // R14: power-on reset only
  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      start_r    <= 1'b0;
      allow_r    <= 1'b0;
      fault_r    <= 1'b0;
      idle_off_r <= 1'b0;
      op_r       <= OP_RESET;
    end else begin
      if (ctrl_wr) begin
        allow_r    <= reg_wr.data[CTRL_ALLOW_BIT];
        idle_off_r <= reg_wr.data[CTRL_IDLE_OFF_BIT];
        op_r       <= wr_op;
      end
      // R6: start set, hardware clear
      if (start_go) begin
        start_r <= 1'b1;
        fault_r <= 1'b0;
      end else if (start_fault || seq_abort) begin
        fault_r <= 1'b1;
      end
      if (seq_r == SEQ_FINISH || seq_abort) start_r <= 1'b0;
    end
  end

  // R10: unused bits read zero
  assign ctrl_rdata = {start_r, allow_r, fault_r, idle_off_r, 8'h00, op_r};
  assign dest_rdata = dest_addr;

  // ==========================================================================
  // Destination registers, cleared by any reset
  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      dest_high_r <= HIGH_RESET;
      dest_low_r  <= LOW_RESET;
    end else if (!sys_rst_b) begin
      dest_high_r <= HIGH_RESET;
      dest_low_r  <= LOW_RESET;
    end else if (reg_wr.en && seq_r == SEQ_IDLE) begin
      if (reg_wr.sel == SEL_DEST_LOW) dest_low_r <= reg_wr.data;
      if (reg_wr.sel == SEL_DEST_HIGH) dest_high_r <= reg_wr.data[7:0];
    end
  end

  // ==========================================================================
  // Holding latches
  // R22: table writes land here
  // R23: no reset, contents unknown
  always_ff @(posedge core_clk) begin
    if (latch_wr.en) latch_mem[latch_wr.index] <= latch_wr.data;
  end

  // ==========================================================================
  // Sequencer
  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      seq_r      <= SEQ_IDLE;
      timer_r    <= 16'h0000;
      idx_r      <= 7'h00;
      last_idx_r <= 7'h00;
      cur_addr_r <= 24'h000000;
      cpu_stall  <= 1'b0;
      flash_cmd  <= '0;
    end else begin
      flash_cmd.erase_page <= 1'b0;
      flash_cmd.erase_chip <= 1'b0;
      flash_cmd.prog_word  <= 1'b0;
      if (seq_abort) begin
        seq_r     <= SEQ_IDLE;
        cpu_stall <= 1'b0;
      end else begin
        case (seq_r)
          SEQ_IDLE: begin
            if (start_go) begin
              // R5: stall from launch on
              cpu_stall <= 1'b1;
              idx_r     <= 7'h00;
              if (wr_op == OP_CHIP_ERASE) begin
                // R4: fixed area, address unused
                // R11: user array only
                cur_addr_r <= 24'h000000;
                seq_r      <= SEQ_ERASE;
              end else if (wr_op == OP_PAGE_ERASE) begin
                // R15: aligned 8-row block
                cur_addr_r <= dest_addr & PAGE_MASK;
                seq_r      <= SEQ_ERASE;
              end else if (wr_op == OP_ROW_PROG) begin
                // R16: whole row from latches
                cur_addr_r <= dest_addr & ROW_MASK;
                last_idx_r <= ROW_LAST;
                seq_r      <= SEQ_PROG;
              end else begin
                // R12: double word at destination
                cur_addr_r <= dest_addr;
                last_idx_r <= DWORD_LAST;
                seq_r      <= SEQ_PROG;
              end
            end
          end
          SEQ_ERASE: begin
            flash_cmd.addr <= cur_addr_r;
            flash_cmd.data <= 24'h000000;
            if (op_r == OP_CHIP_ERASE) begin
              flash_cmd.erase_chip <= 1'b1;
              timer_r              <= 16'(CHIP_ERASE_CYCLES - 1);
            end else begin
              flash_cmd.erase_page <= 1'b1;
              timer_r              <= 16'(PAGE_ERASE_CYCLES - 1);
            end
            idx_r <= last_idx_r;
            seq_r <= SEQ_WAIT;
          end
          SEQ_PROG: begin
            flash_cmd.prog_word <= 1'b1;
            flash_cmd.addr      <= cur_addr_r;
            flash_cmd.data      <= latch_mem[idx_r];
            timer_r             <= 16'(WORD_PROG_CYCLES - 1);
            seq_r               <= SEQ_WAIT;
          end
          // Self-timed wait, then next word or finish
          SEQ_WAIT: begin
            if (timer_r != 16'h0000) begin
              timer_r <= timer_r - 16'h0001;
            end else if (idx_r != last_idx_r) begin
              idx_r      <= idx_r + 7'h01;
              cur_addr_r <= cur_addr_r + WORD_STEP;
              seq_r      <= SEQ_PROG;
            end else begin
              seq_r <= SEQ_FINISH;
            end
          end
          SEQ_FINISH: begin
            cpu_stall <= 1'b0;
            seq_r     <= SEQ_IDLE;
          end
          default: seq_r <= SEQ_IDLE;
        endcase
      end
    end
  end

  // ==========================================================================
  // Idle power
  // R9: power off or standby
  always_ff @(posedge core_clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      mem_power_off <= 1'b0;
      mem_standby   <= 1'b0;
    end else begin
      mem_power_off <= idle_req && idle_off_r;
      mem_standby   <= idle_req && !idle_off_r;
    end
  end

endmodule

// [include/flash_pkg.sv]
// Constants, codes and carrier types for the flash program/erase controller
package flash_pkg;

  // ==========================================================================
  // Control register field positions
  localparam int CTRL_START_BIT    = 15;
  localparam int CTRL_ALLOW_BIT    = 14;
  localparam int CTRL_FAULT_BIT    = 13;
  localparam int CTRL_IDLE_OFF_BIT = 12;
  localparam int CTRL_OP_MSB       = 3;
  localparam int CTRL_OP_LSB       = 0;

  // ==========================================================================
  // Reset values
  localparam logic [3:0]  OP_RESET   = 4'h0;
  localparam logic [7:0]  HIGH_RESET = 8'h00;
  localparam logic [15:0] LOW_RESET  = 16'h0000;

  // ==========================================================================
  // Operation select codes
  localparam logic [3:0] OP_CHIP_ERASE = 4'he;
  localparam logic [3:0] OP_UNUSED     = 4'h4;
  localparam logic [3:0] OP_PAGE_ERASE = 4'h3;
  localparam logic [3:0] OP_ROW_PROG   = 4'h2;
  localparam logic [3:0] OP_DWORD_PROG = 4'h1;

  // ==========================================================================
  // Unlock key values and register selects
  localparam logic [15:0] KEY_FIRST  = 16'h0055;
  localparam logic [15:0] KEY_SECOND = 16'h00aa;

  localparam logic [1:0] SEL_CTRL      = 2'h0;
  localparam logic [1:0] SEL_DEST_LOW  = 2'h1;
  localparam logic [1:0] SEL_DEST_HIGH = 2'h2;
  localparam logic [1:0] SEL_KEY       = 2'h3;

  // ==========================================================================
  // Array geometry (addresses count two units per instruction)
  localparam int          ROW_WORDS   = 128;
  localparam logic [6:0]  ROW_LAST    = 7'h7f;
  localparam logic [6:0]  DWORD_LAST  = 7'h01;
  localparam logic [23:0] PAGE_MASK   = 24'hfff800;
  localparam logic [23:0] ROW_MASK    = 24'hffff00;
  localparam logic [23:0] WORD_STEP   = 24'h000002;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ           = 200;
  localparam int PAGE_ERASE_US     = 20;
  localparam int CHIP_ERASE_US     = 40;
  localparam int WORD_PROG_NS      = 50;
  localparam int PAGE_ERASE_CYCLES = PAGE_ERASE_US * CLK_MHZ;
  localparam int CHIP_ERASE_CYCLES = CHIP_ERASE_US * CLK_MHZ;
  localparam int WORD_PROG_CYCLES  = (WORD_PROG_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic        en;
    logic [1:0]  sel;
    logic [15:0] data;
  } reg_wr_s;

  typedef struct packed {
    logic        en;
    logic [6:0]  index;
    logic [23:0] data;
  } latch_wr_s;

  typedef struct packed {
    logic        erase_page;
    logic        erase_chip;
    logic        prog_word;
    logic [23:0] addr;
    logic [23:0] data;
  } flash_cmd_s;

endpackage

// [sim/flash_ctrl_checker_sva.sv]
// Port-level assertions for the flash program/erase controller
module flash_ctrl_checker (
  input wire logic                  core_clk,
  input wire logic                  rst_b,
  input wire logic                  sys_rst_b,
  input wire logic                  idle_req,
  input wire flash_pkg::reg_wr_s    reg_wr,
  input wire flash_pkg::latch_wr_s  latch_wr,
  input wire logic [15:0]           ctrl_rdata,
  input wire logic [23:0]           dest_rdata,
  input wire logic                  cpu_stall,
  input wire logic                  mem_power_off,
  input wire logic                  mem_standby,
  input wire flash_pkg::flash_cmd_s flash_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_pkg::*;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  unused_bits_zero_a: assert property (ctrl_rdata[11:4] == 8'h00)
    else $error("unused control bits not zero");
  start_bit_clear_a: assert property ($fell(cpu_stall) |-> !ctrl_rdata[15])
    else $error("start bit still set after stall ends");
  cmd_in_stall_a: assert property (
    (flash_cmd.erase_page || flash_cmd.erase_chip || flash_cmd.prog_word) |-> cpu_stall)
    else $error("flash command issued without stall");
  chip_addr_zero_a: assert property (flash_cmd.erase_chip |-> flash_cmd.addr == 24'h0)
    else $error("chip erase uses destination");
  page_aligned_a: assert property (
    flash_cmd.erase_page |-> flash_cmd.addr == (dest_rdata & PAGE_MASK))
    else $error("page erase address not the aligned destination");
  // Bad start: enable clear or the unused code, while idle
  refused_start_a: assert property (
    reg_wr.en && reg_wr.sel == SEL_CTRL && reg_wr.data[15] && !cpu_stall
    && (!reg_wr.data[14] || reg_wr.data[3:0] == OP_UNUSED)
    |=> (ctrl_rdata[13] && !cpu_stall) [*2])
    else $error("bad start not refused");
  power_off_a: assert property (
    mem_power_off == $past(idle_req && ctrl_rdata[12]))
    else $error("power off does not follow idle select");
  standby_a: assert property (
    mem_standby == $past(idle_req && !ctrl_rdata[12]))
    else $error("standby does not follow idle select");
  sysrst_keeps_ctrl_a: assert property (
    !sys_rst_b && !cpu_stall && !reg_wr.en |=> ctrl_rdata == $past(ctrl_rdata))
    else $error("other reset changed control bits");
endmodule

bind flash_program_erase_controller flash_ctrl_checker chk (
  .core_clk(core_clk), .rst_b(rst_b), .sys_rst_b(sys_rst_b), .idle_req(idle_req),
  .reg_wr(reg_wr), .latch_wr(latch_wr), .ctrl_rdata(ctrl_rdata),
  .dest_rdata(dest_rdata), .cpu_stall(cpu_stall), .mem_power_off(mem_power_off),
  .mem_standby(mem_standby), .flash_cmd(flash_cmd)
);

// [sim/core_model.sv]
// Behavioural processor core issuing register writes and table writes
module core_model (
  input  wire logic            core_clk,
  output flash_pkg::reg_wr_s   reg_wr,
  output flash_pkg::latch_wr_s latch_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  import flash_pkg::*;

  initial begin
    reg_wr = '0;
    latch_wr = '0;
  end

  // One-cycle write; released bus shows inverted data, never a stale copy
  task automatic wr(input logic [1:0] sel, input logic [15:0] data);
    @(negedge core_clk);
    reg_wr = '{en: 1'b1, sel: sel, data: data};
    @(negedge core_clk);
    reg_wr = '{en: 1'b0, sel: ~sel, data: ~data};
  endtask

  task automatic ltch(input logic [6:0] index, input logic [23:0] data);
    @(negedge core_clk);
    latch_wr = '{en: 1'b1, index: index, data: data};
    @(negedge core_clk);
    latch_wr = '{en: 1'b0, index: ~index, data: ~data};
  endtask

  // keys back to back, then start with the same control value
  task automatic start(input logic [15:0] ctrl);
    wr(SEL_KEY, KEY_FIRST);
    wr(SEL_KEY, KEY_SECOND);
    // reserved bits stay zero, enable and code in one write
    wr(SEL_CTRL, (ctrl & 16'h500f) | 16'h8000);
    // two idle instructions after the start
    repeat (2) @(negedge core_clk);
  endtask
endmodule

// [sim/flash_program_erase_controller_tb.sv]
// Self-checking testbench for the flash program/erase controller
module flash_program_erase_controller_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_pkg::*;

  logic core_clk, rst_b, sys_rst_b, idle_req, cpu_stall, mem_power_off, mem_standby;
  logic [15:0] ctrl_rdata;
  logic [23:0] dest_rdata;
  reg_wr_s     reg_wr;
  latch_wr_s   latch_wr;
  flash_cmd_s  flash_cmd;
  logic [50:0] cmds[$];
  int          bad_count, n_compared, cycles;

  // Default timings kept, so the real erase and program counts are exercised
  flash_program_erase_controller uut (.core_clk(core_clk), .rst_b(rst_b), .sys_rst_b(sys_rst_b),
    .idle_req(idle_req), .reg_wr(reg_wr), .latch_wr(latch_wr), .ctrl_rdata(ctrl_rdata),
    .dest_rdata(dest_rdata), .cpu_stall(cpu_stall), .mem_power_off(mem_power_off),
    .mem_standby(mem_standby), .flash_cmd(flash_cmd));
  core_model core (.core_clk(core_clk), .reg_wr(reg_wr), .latch_wr(latch_wr));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Strobes are one cycle wide, so each strobe is logged once
  always @(negedge core_clk) begin
    if (rst_b && |{flash_cmd.erase_page, flash_cmd.erase_chip, flash_cmd.prog_word})
      cmds.push_back(flash_cmd);
  end

  // Hang guard: the erases dominate, about 14000 cycles in all
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 25000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [51:0] seen, input logic [51:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [23:0] pat(input logic [6:0] i);
    return {8'ha5, 1'b0, i, 1'b0, i};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic setup(input logic [3:0] op, input logic [23:0] dst);
    cmds.delete();
    core.wr(SEL_CTRL, {12'h400, op});
    core.wr(SEL_DEST_LOW, dst[15:0]);
    core.wr(SEL_DEST_HIGH, {8'h00, dst[23:16]});
  endtask

  // Bounded wait for the stall to drop, then one more cycle for readback
  task automatic settle();
    int n;
    n = 0;
    while (cpu_stall !== 1'b0 && n < 9000) begin
      tick(1);
      n++;
    end
    tick(1);
    check(n < 9000, 1, "stall released");
  endtask

  task automatic t_regs();
    check(ctrl_rdata, 16'h0000, "control after reset");
    core.wr(SEL_CTRL, 16'h73f2);
    core.wr(SEL_DEST_LOW, 16'h1234);
    core.wr(SEL_DEST_HIGH, 16'h0056);
    tick(1);
    check(ctrl_rdata, 16'h5002, "control readback");
    check(dest_rdata, 24'h561234, "destination pair");
    sys_rst_b = 1'b0;
    tick(1);
    sys_rst_b = 1'b1;
    tick(1);
    check(ctrl_rdata, 16'h5002, "control after other reset");
    check(dest_rdata, 24'h000000, "destination after other reset");
    idle_req = 1'b1;
    tick(2);
    check({mem_power_off, mem_standby}, 2'b10, "idle power off");
    core.wr(SEL_CTRL, 16'h4002);
    tick(2);
    check({mem_power_off, mem_standby}, 2'b01, "idle standby");
    idle_req = 1'b0;
    $display("test regs done");
  endtask

  task automatic t_row();
    for (int i = 0; i < 128; i++) core.ltch(i[6:0], pat(i[6:0]));
    setup(OP_ROW_PROG, 24'h0004c6);
    core.start(16'h4002);
    settle();
    check(cmds.size(), 128, "row strobes");
    foreach (cmds[i]) check(cmds[i], {3'b001, 24'h000400 + 24'(2 * i), pat(i[6:0])}, "row");
    check(ctrl_rdata, 16'h4002, "row done");
    $display("test row done");
  endtask

  // Double word from latches 0 and 1, also clears the fault flag
  task automatic good();
    setup(OP_DWORD_PROG, 24'h00100a);
    core.start(16'h4001);
    settle();
    check(cmds.size(), 2, "double word strobes");
    check(cmds[0], {3'b001, 24'h00100a, pat(0)}, "double word first");
    check(cmds[1], {3'b001, 24'h00100c, pat(1)}, "double word second");
    check(ctrl_rdata, 16'h4001, "fault clear after success");
  endtask

  task automatic t_refused();
    logic [17:0] tbl [8];
    tbl = '{{2'd0, 16'h4003}, {2'd1, 16'h0003}, {2'd1, 16'h4000}, {2'd1, 16'h4004},
            {2'd1, 16'h4005}, {2'd1, 16'h400f}, {2'd2, 16'h4003}, {2'd3, 16'h4003}};
    foreach (tbl[k]) begin
      good();
      cmds.delete();
      if (tbl[k][17:16] != 2'd0) core.wr(SEL_KEY, KEY_FIRST);
      if (tbl[k][17:16] == 2'd2) core.wr(SEL_KEY, KEY_FIRST);
      if (tbl[k][17:16] == 2'd3) core.wr(SEL_DEST_LOW, 16'h0000);
      if (tbl[k][17:16] != 2'd0) core.wr(SEL_KEY, KEY_SECOND);
      core.wr(SEL_CTRL, tbl[k][15:0] | 16'h8000);
      tick(2);
      check({cpu_stall, ctrl_rdata[15], ctrl_rdata[13]}, 3'b001, "refused start");
      check(cmds.size(), 0, "no operation");
    end
    $display("test refused done");
  endtask

  task automatic t_erase();
    setup(OP_PAGE_ERASE, 24'h0127fe);
    core.start(16'h4003);
    settle();
    check(cmds.size(), 1, "page erase strobes");
    check(cmds[0][50:24], {3'b100, 24'h012000}, "page erase");
    check(ctrl_rdata, 16'h4003, "page done");
    setup(OP_CHIP_ERASE, 24'h3456a8);
    core.start(16'h400e);
    settle();
    check(cmds.size(), 1, "chip erase strobes");
    check(cmds[0][50:24], {3'b010, 24'h000000}, "chip erase");
    $display("test erase done");
  endtask

  task automatic t_abort();
    setup(OP_PAGE_ERASE, 24'h000800);
    core.start(16'h4003);
    check(cpu_stall, 1'b1, "stalled in erase");
    sys_rst_b = 1'b0;
    tick(1);
    sys_rst_b = 1'b1;
    settle();
    check(ctrl_rdata, 16'h6003, "early termination");
    $display("test abort done");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    sys_rst_b = 1'b1;
    idle_req = 1'b0;
    tick(12);
    rst_b = 1'b1;
    tick(4);
    t_regs();
    t_row();
    t_refused();
    t_erase();
    t_abort();
    tally_and_finish();
  end
endmodule
